/* File: logic/bit_sync.sv */
// two-stage synchroniser for levels from another clock domain
// assumes each bit is a level or a toggle, never a one-edge pulse
`timescale 1ns/1ns
module bit_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

/* File: logic/eeprom_cfg.svh */
// constants for the serial word memory and its host end
// assumes includers use these names only, never the raw figures
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

// ----------------------------------------
// array shape
// ----------------------------------------
`define WORD_W        16
`define ADDR_W        8
`define OP_W          8
`define ERASED_WORD   16'hffff

// ----------------------------------------
// frame layout, counted in rising edges
// ----------------------------------------
`define CNT_W         6
`define OP_END        6'h08
`define ADDR_END      6'h0f
`define RD_START      6'h10
`define DATA_END      6'h1f
`define FRAME_BITS    6'h20
`define CTRL_BITS     6'h10
`define LAST_BIT      4'hf

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_WRITE      8'ha4
`define OP_READ       8'ha8
`define OP_PEN        8'ha3
`define OP_PDIS       8'ha0
`define OP_FILL       8'haf

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS        100
`define PROG_MAX_NS   10000000
`define PROG_CYC      (`PROG_MAX_NS / `CLK_NS)
`define MIN_DESEL_NS  250
`define MIN_DESEL_CYC ((`MIN_DESEL_NS + `CLK_NS - 1) / `CLK_NS)
`define SK_HALF_CYC   4
`define STAT_WAIT_CYC 4
`define STAT_SEL_CYC  1
`define TMR_W         8

`endif

/* File: logic/eeprom_device.sv */
// memory end: serial command decoder, read shifter, self-timed programming
// assumes clk is the local timebase and the link clock comes from the host
`timescale 1ns/1ns
`include "eeprom_cfg.svh"
module eeprom_device #(
   parameter int PROG_CYC = `PROG_CYC
) (
   input  wire logic  clk,
   input  wire logic  rst,
   eeprom_link_if.dev link,
   output logic       busy,
   output logic       prog_enabled
);
   import eeprom_pkg::*;

   localparam int PCW = $clog2(PROG_CYC + 1);

   // ----------------------------------------
   // storage, owned by the clk domain
   // ----------------------------------------
   logic [`WORD_W-1:0] mem_q [2**`ADDR_W];

   // ----------------------------------------
   // link domain: frame capture
   // ----------------------------------------
   logic               sk_at_sel_q;
   logic               started_q;
   logic [`CNT_W-1:0]  cnt_q;
   logic [`OP_W-1:0]   op_q;
   logic [`ADDR_W-1:0] addr_q;
   logic [`WORD_W-1:0] data_q;
   logic               take;
   logic               wr_tgl_q;
   logic               en_tgl_q;
   logic               dis_tgl_q;
   logic               status_mode;

   // level of the clock at the select edge picks command or status
   always_ff @(negedge link.cs_n) begin
      sk_at_sel_q <= link.shift_clock_n;
   end

   // in status mode leading zeros are skipped until the opcode's first one
   always_comb begin
      if (!started_q) begin
         take = sk_at_sel_q || link.serial_in;
      end else begin
         take = (cnt_q != `FRAME_BITS);
      end
   end

   always_ff @(posedge link.shift_clock_n or posedge link.cs_n) begin
      if (link.cs_n) begin
         started_q <= 1'b0;
         cnt_q     <= '0;
      end else if (take) begin
         started_q <= 1'b1;
         cnt_q     <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge link.shift_clock_n) begin
      if (take && (cnt_q < `OP_END)) begin
         op_q <= {op_q[`OP_W-2:0], link.serial_in};
      end
      if (take && (cnt_q >= `OP_END) && (cnt_q <= `ADDR_END)) begin
         addr_q <= {addr_q[`ADDR_W-2:0], link.serial_in};
      end
      if (take && (cnt_q >= `RD_START) && (cnt_q <= `DATA_END)) begin
         data_q <= {data_q[`WORD_W-2:0], link.serial_in};
      end
   end

   // toggles survive deselect so the clk side never misses a command
   always_ff @(posedge link.shift_clock_n or posedge rst) begin
      if (rst) begin
         wr_tgl_q  <= 1'b0;
         en_tgl_q  <= 1'b0;
         dis_tgl_q <= 1'b0;
      end else if (take && !link.cs_n) begin
         if (cnt_q == `ADDR_END && op_q == `OP_PEN) begin
            en_tgl_q <= ~en_tgl_q;
         end
         if (cnt_q == `ADDR_END && op_q == `OP_PDIS) begin
            dis_tgl_q <= ~dis_tgl_q;
         end
         if (cnt_q == `DATA_END && op_q == `OP_WRITE) begin
            wr_tgl_q <= ~wr_tgl_q;
         end
      end
   end

   // ----------------------------------------
   // link domain: read shifter
   // ----------------------------------------
   logic               reading_q;
   logic [3:0]         rbit_q;
   logic [`WORD_W-1:0] sh_q;
   logic [`ADDR_W-1:0] rd_addr_q;
   logic [`ADDR_W-1:0] load_addr;
   logic               load;

   assign load_addr = reading_q ? rd_addr_q : addr_q;
   assign load      = !reading_q || (rbit_q == 4'h0);

   // array words only change while busy, so reads see settled data
   always_ff @(negedge link.shift_clock_n or posedge link.cs_n) begin
      if (link.cs_n) begin
         reading_q <= 1'b0;
         rbit_q    <= 4'h0;
         sh_q      <= '0;
         rd_addr_q <= '0;
      end else if (op_q == `OP_READ && cnt_q >= `RD_START) begin
         reading_q <= 1'b1;
         if (load) begin
            sh_q      <= mem_q[load_addr];
            rd_addr_q <= load_addr + 1'b1;
            rbit_q    <= `LAST_BIT;
         end else begin
            sh_q   <= {sh_q[`WORD_W-2:0], 1'b0};
            rbit_q <= rbit_q - 1'b1;
         end
      end
   end

   // ----------------------------------------
   // output pin
   // ----------------------------------------
   logic busy_q;

   assign status_mode  = !link.cs_n && !sk_at_sel_q && !started_q;
   assign link.do_out  = status_mode ? ~busy_q : sh_q[`WORD_W-1];
   assign link.do_oe_n = ~(status_mode || reading_q);

   // ----------------------------------------
   // clk domain: crossings
   // ----------------------------------------
   logic [3:0] sync_w;
   logic [2:0] seen_q;
   logic       ev_wr;
   logic       ev_en;
   logic       ev_dis;
   logic       guard;

   bit_sync #(
      .WIDTH (4)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({wr_tgl_q, en_tgl_q, dis_tgl_q, link.hold_reset}),
      .q   (sync_w)
   );

   assign ev_wr  = sync_w[3] ^ seen_q[2];
   assign ev_en  = sync_w[2] ^ seen_q[1];
   assign ev_dis = sync_w[1] ^ seen_q[0];
   assign guard  = sync_w[0];

   always_ff @(posedge clk) begin
      if (rst) begin
         seen_q <= '0;
      end else begin
         seen_q <= sync_w[3:1];
      end
   end

   // ----------------------------------------
   // clk domain: enable latch
   // ----------------------------------------
   logic wen_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         wen_q <= 1'b0;
      end else if (ev_en) begin
         wen_q <= 1'b1;
      end else if (ev_dis) begin
         wen_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // clk domain: self-timed programming
   // ----------------------------------------
   logic [PCW-1:0]     pcnt_q;
   logic [`ADDR_W-1:0] paddr_q;
   logic [`WORD_W-1:0] pdata_q;
   logic               start;
   logic               finish;

   // address and data sit still once the frame is done
   assign start  = ev_wr && wen_q && !guard && !busy_q;
   assign finish = busy_q && !guard && (pcnt_q == PCW'(PROG_CYC - 1));

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_q <= 1'b0;
         pcnt_q <= '0;
      end else if (start) begin
         busy_q <= 1'b1;
         pcnt_q <= '0;
      end else if (busy_q && guard) begin
         busy_q <= 1'b0;
      end else if (finish) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         pcnt_q <= pcnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (start) begin
         paddr_q <= addr_q;
         pdata_q <= data_q;
      end
   end

   // an aborted word stays erased, which stands for undefined contents
   always_ff @(posedge clk) begin
      if (start) begin
         mem_q[addr_q] <= `ERASED_WORD;
      end else if (finish) begin
         mem_q[paddr_q] <= pdata_q;
      end
   end

   assign busy         = busy_q;
   assign prog_enabled = wen_q;
endmodule

/* File: logic/eeprom_host.sv */
// host end: makes the link clock by division and runs one frame per command
// assumes the user holds a command until cmd_ready and keeps guard low for writes
`timescale 1ns/1ns
`include "eeprom_cfg.svh"
module eeprom_host (
   input  wire logic                  clk,
   input  wire logic                  rst,
   eeprom_link_if.host                link,
   input  wire logic                  cmd_valid,
   output logic                       cmd_ready,
   input  wire eeprom_pkg::host_cmd_t cmd_op,
   input  wire logic [`ADDR_W-1:0]    cmd_addr,
   input  wire logic [`WORD_W-1:0]    cmd_data,
   input  wire logic                  guard,
   output logic                       rsp_valid,
   output logic [`WORD_W-1:0]         rsp_data
);
   import eeprom_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   host_state_t        state_q;
   logic [`TMR_W-1:0]  tmr_q;
   logic [`CNT_W-1:0]  bit_q;
   logic [`CNT_W-1:0]  nbits_q;
   logic [31:0]        frame_q;
   logic               is_read_q;
   logic [`WORD_W-1:0] rx_q;
   logic               cs_n_q;
   logic               sk_q;
   logic               guard_q;
   logic               do_s;
   logic               tmr_end;
   logic [`OP_W-1:0]   opcode;

   bit_sync #(
      .WIDTH (1)
   ) u_do_sync (
      .clk (clk),
      .rst (rst),
      .d   (link.do_line),
      .q   (do_s)
   );

   // factory fill is never produced
   always_comb begin
      unique case (cmd_op)
         CMD_READ:  opcode = `OP_READ;
         CMD_WRITE: opcode = `OP_WRITE;
         CMD_PEN:   opcode = `OP_PEN;
         CMD_PDIS:  opcode = `OP_PDIS;
         default:   opcode = `OP_PDIS;
      endcase
   end

   assign tmr_end   = (tmr_q == `TMR_W'(`SK_HALF_CYC - 1));
   assign cmd_ready = (state_q == H_IDLE);

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q   <= H_GAP;
         tmr_q     <= '0;
         bit_q     <= '0;
         cs_n_q    <= 1'b1;
         sk_q      <= 1'b1;
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         tmr_q     <= tmr_q + 1'b1;
         unique case (state_q)
            H_GAP: begin
               sk_q <= 1'b1;
               if (tmr_q == `TMR_W'(`MIN_DESEL_CYC - 1)) begin
                  state_q <= H_IDLE;
               end
            end
            H_IDLE: begin
               tmr_q <= '0;
               if (cmd_valid && cmd_op == CMD_STATUS) begin
                  sk_q    <= 1'b0;
                  state_q <= H_STAT;
               end else if (cmd_valid) begin
                  cs_n_q  <= 1'b0;
                  bit_q   <= '0;
                  state_q <= H_SEL;
               end
            end
            H_SEL: begin
               if (tmr_end) begin
                  tmr_q   <= '0;
                  sk_q    <= 1'b0;
                  state_q <= H_LOW;
               end
            end
            H_LOW: begin
               if (tmr_end) begin
                  tmr_q   <= '0;
                  sk_q    <= 1'b1;
                  state_q <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (tmr_end && bit_q == nbits_q - 1'b1) begin
                  tmr_q     <= '0;
                  cs_n_q    <= 1'b1;
                  rsp_valid <= is_read_q;
                  state_q   <= H_GAP;
               end else if (tmr_end) begin
                  tmr_q   <= '0;
                  bit_q   <= bit_q + 1'b1;
                  sk_q    <= 1'b0;
                  state_q <= H_LOW;
               end
            end
            H_STAT: begin
               if (tmr_q == `TMR_W'(`STAT_SEL_CYC)) begin
                  cs_n_q <= 1'b0;
               end
               if (tmr_q == `TMR_W'(`STAT_WAIT_CYC + 1)) begin
                  tmr_q     <= '0;
                  cs_n_q    <= 1'b1;
                  rsp_valid <= 1'b1;
                  state_q   <= H_GAP;
               end
            end
            default: begin
               state_q <= H_GAP;
            end
         endcase
      end
   end

   // ----------------------------------------
   // frame data and reply
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (state_q == H_IDLE && cmd_valid) begin
         frame_q   <= {opcode, cmd_addr, cmd_data};
         is_read_q <= (cmd_op == CMD_READ);
         if (cmd_op == CMD_PEN || cmd_op == CMD_PDIS) begin
            nbits_q <= `CTRL_BITS;
         end else begin
            nbits_q <= `FRAME_BITS;
         end
      end else if (state_q == H_HIGH && tmr_end) begin
         frame_q <= {frame_q[30:0], 1'b0};
      end
   end

   // sample late in the high phase, after the synchroniser has settled
   always_ff @(posedge clk) begin
      if (state_q == H_HIGH && tmr_end && is_read_q && bit_q >= `RD_START) begin
         rx_q <= {rx_q[`WORD_W-2:0], do_s};
      end
      if (state_q == H_HIGH && tmr_end && bit_q == nbits_q - 1'b1) begin
         rsp_data <= {rx_q[`WORD_W-2:0], do_s};
      end else if (state_q == H_STAT && tmr_q == `TMR_W'(`STAT_WAIT_CYC + 1)) begin
         rsp_data <= {{(`WORD_W - 1){1'b0}}, do_s};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         guard_q <= 1'b0;
      end else begin
         guard_q <= guard;
      end
   end

   assign link.cs_n          = cs_n_q;
   assign link.shift_clock_n = sk_q;
   assign link.serial_in     = frame_q[31];
   assign link.hold_reset    = guard_q;
endmodule

/* File: logic/eeprom_link_if.sv */
// the serial pins between the host and the memory
// assumes the output line has a pull-up when nobody drives it
`timescale 1ns/1ns
interface eeprom_link_if;
   logic cs_n;
   logic shift_clock_n;
   logic serial_in;
   logic hold_reset;
   logic do_out;
   logic do_oe_n;
   logic do_line;

   // undriven line reads high, as with an external pull-up
   assign do_line = do_oe_n ? 1'b1 : do_out;

   modport dev (
      input  cs_n,
      input  shift_clock_n,
      input  serial_in,
      input  hold_reset,
      output do_out,
      output do_oe_n
   );

   modport host (
      output cs_n,
      output shift_clock_n,
      output serial_in,
      output hold_reset,
      input  do_line
   );
endinterface

/* File: logic/eeprom_pkg.sv */
// types shared by the memory end and the host end
// assumes eeprom_cfg.svh is on the include path
package eeprom_pkg;

   // ----------------------------------------
   // host commands and states
   // ----------------------------------------
   typedef enum logic [2:0] {
      CMD_READ   = 3'b000,
      CMD_WRITE  = 3'b001,
      CMD_PEN    = 3'b010,
      CMD_PDIS   = 3'b011,
      CMD_STATUS = 3'b100
   } host_cmd_t;

   typedef enum logic [2:0] {
      H_GAP  = 3'b000,
      H_IDLE = 3'b001,
      H_SEL  = 3'b010,
      H_LOW  = 3'b011,
      H_HIGH = 3'b100,
      H_STAT = 3'b101
   } host_state_t;

endpackage

/* File: test/eeprom_link_sva.sv */
// link checker: watches the serial pins and the memory end's status flags
// assumes one shared clk samples the link; instantiated beside the interface
`timescale 1ns/1ns
`include "eeprom_cfg.svh"
module eeprom_link_sva #(
   parameter int PROG_CYC = 40
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic shift_clock_n,
   input wire logic serial_in,
   input wire logic hold_reset,
   input wire logic do_out,
   input wire logic do_oe_n,
   input wire logic busy,
   input wire logic prog_enabled
);
   // ----------------------------------------
   // frame tracking
   // ----------------------------------------
   logic [5:0]  rise_q;
   logic [7:0]  op_q;
   logic        stat_q;
   logic [15:0] busy_cnt_q;

   always_ff @(posedge clk) begin
      if (rst || cs_n) begin
         rise_q <= 6'h00;
      end else if ($rose(shift_clock_n) && rise_q != 6'h3f) begin
         rise_q <= rise_q + 6'h01;
      end
   end

   // opcode bits arrive first, msb first
   always_ff @(posedge clk) begin
      if (rst) begin
         op_q <= 8'h00;
      end else if (!cs_n && $rose(shift_clock_n) && rise_q < `OP_END) begin
         op_q <= {op_q[6:0], serial_in};
      end
   end

   always_ff @(posedge clk) begin
      if (rst || cs_n) begin
         stat_q <= 1'b0;
      end else if ($fell(cs_n) && !shift_clock_n) begin
         stat_q <= 1'b1;
      end else if ($rose(shift_clock_n) && serial_in) begin
         stat_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !busy) begin
         busy_cnt_q <= 16'h0000;
      end else begin
         busy_cnt_q <= busy_cnt_q + 16'h0001;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_FLOAT_DESEL: assert property (cs_n |-> do_oe_n)
      else $error("output driven while deselected");
   AST_STATUS_LEVEL: assert property (
      stat_q && !cs_n && !$rose(shift_clock_n)
      |-> !do_oe_n && (do_out == !busy))
      else $error("status output wrong");
   // the select edge itself is skipped: status mode is not yet tracked there
   AST_FLOAT_EARLY: assert property (
      !cs_n && !$fell(cs_n) && !stat_q
      && (rise_q < `RD_START || op_q != `OP_READ) |-> do_oe_n)
      else $error("output driven outside read data");
   AST_READ_DRIVE: assert property (
      !cs_n && op_q == `OP_READ && rise_q >= `RD_START
      && !shift_clock_n |-> !do_oe_n)
      else $error("read data not driven");
   AST_WRITE_BUSY: assert property (
      $rose(shift_clock_n) && !cs_n && rise_q == `DATA_END
      && op_q == `OP_WRITE && prog_enabled && !hold_reset && !busy |-> ##[1:6] busy)
      else $error("write did not start programming");
   AST_WRITE_LOCKED: assert property (
      $rose(shift_clock_n) && !cs_n && rise_q == `DATA_END
      && op_q == `OP_WRITE && !prog_enabled && !busy |-> !busy [*8])
      else $error("write ran with latch clear");
   AST_WRITE_GUARDED: assert property (
      $rose(shift_clock_n) && !cs_n && rise_q == `DATA_END
      && op_q == `OP_WRITE && hold_reset && !busy |-> !busy [*8])
      else $error("write ran with guard high");
   AST_ABORT: assert property (busy && hold_reset |-> ##[0:5] !busy)
      else $error("programming not aborted");
   AST_ENABLE_SET: assert property (
      $rose(shift_clock_n) && !cs_n && rise_q == `ADDR_END
      && op_q == `OP_PEN |-> ##[1:6] prog_enabled)
      else $error("enable latch not set");
   AST_DISABLE_CLR: assert property (
      $rose(shift_clock_n) && !cs_n && rise_q == `ADDR_END
      && op_q == `OP_PDIS |-> ##[1:6] !prog_enabled)
      else $error("enable latch not cleared");
   AST_PROG_TIME: assert property (
      $fell(busy) && !hold_reset
      |-> int'(busy_cnt_q) >= PROG_CYC - 2 && int'(busy_cnt_q) <= PROG_CYC + 2)
      else $error("programming time wrong");
   AST_DESEL_GAP: assert property ($rose(cs_n) |-> ##1 cs_n [*2])
      else $error("deselect gap too short");

   cover property ($rose(busy));
   cover property (stat_q && !cs_n && busy);
   cover property (busy && hold_reset);
   cover property (!do_oe_n && op_q == `OP_READ);
endmodule

/* File: test/tb_top.sv */
// bench: host end drives the memory end over the link interface
// assumes both ends share clk; the host divides it to make the link clock
`timescale 1ns/1ns
`include "eeprom_cfg.svh"
module tb_top;
   import eeprom_pkg::*;
   localparam int PROG = 40;

   logic              clk;
   logic              rst;
   logic              cmd_valid;
   logic              cmd_ready;
   host_cmd_t         cmd_op;
   logic [7:0]        cmd_addr;
   logic [15:0]       cmd_data;
   logic              guard;
   logic              rsp_valid;
   logic [15:0]       rsp_data;
   logic              busy;
   logic              prog_enabled;
   int                err_total;
   int                checks_done;
   int                cyc_count;

   eeprom_link_if eeprom_link_if_inst ();

   eeprom_device #(.PROG_CYC(PROG)) eeprom_device_inst (
      .clk(clk), .rst(rst), .link(eeprom_link_if_inst),
      .busy(busy), .prog_enabled(prog_enabled));

   eeprom_host eeprom_host_inst (
      .clk(clk), .rst(rst), .link(eeprom_link_if_inst),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .guard(guard),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));

   eeprom_link_sva #(.PROG_CYC(PROG)) eeprom_link_sva_inst (
      .clk(clk), .rst(rst), .cs_n(eeprom_link_if_inst.cs_n),
      .shift_clock_n(eeprom_link_if_inst.shift_clock_n),
      .serial_in(eeprom_link_if_inst.serial_in),
      .hold_reset(eeprom_link_if_inst.hold_reset),
      .do_out(eeprom_link_if_inst.do_out), .do_oe_n(eeprom_link_if_inst.do_oe_n),
      .busy(busy), .prog_enabled(prog_enabled));

   always #50 clk = ~clk;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc_count++;
      if (cyc_count == 30000) begin
         err_total++;
         $display("MISMATCH t=%0t bench ran out of time", $time);
         conclude();
      end
   end

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 600) begin
         step(1);
         n++;
      end
      // a host stuck outside idle must not pass quietly
      if (n == 600) begin
         err_total++;
         $display("MISMATCH t=%0t host never ready", $time);
      end
   endtask

   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (busy !== v && n < lim) begin
         step(1);
         n++;
      end
      if (n == lim) begin
         err_total++;
         $display("MISMATCH t=%0t busy never reached %b", $time, v);
      end
   endtask

   task automatic issue(input host_cmd_t op, input logic [7:0] a, input logic [15:0] d);
      wait_ready();
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1'b1;
      step(1);
      cmd_valid = 1'b0;
   endtask

   task automatic get_rsp(output logic [15:0] v);
      int n;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 600) begin
         step(1);
         n++;
      end
      // a missing reply would otherwise compare stale data
      if (n == 600) begin
         err_total++;
         $display("MISMATCH t=%0t no reply", $time);
      end
      v = rsp_data;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] v;
      issue(CMD_READ, a, 16'h0000);
      get_rsp(v);
      cmp_word(v, exp);
   endtask

   // status bit0 is one when ready
   task automatic st(input logic exp);
      logic [15:0] v;
      issue(CMD_STATUS, 8'h00, 16'h0000);
      get_rsp(v);
      cmp_bit(v[0], exp);
   endtask

   // busy is already up by the time the host is idle again
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic eb);
      issue(CMD_WRITE, a, d);
      wait_ready();
      cmp_bit(busy, eb);
   endtask

   task automatic latch(input host_cmd_t op, input logic exp);
      issue(op, 8'h5a, 16'h0000);
      wait_ready();
      cmp_bit(prog_enabled, exp);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_locked();
      cmp_bit(prog_enabled, 1'b0);
      wr(8'h12, 16'h1234, 1'b0);
      $display("test locked done");
   endtask

   task automatic t_write_read();
      latch(CMD_PEN, 1'b1);
      wr(8'h12, 16'ha55a, 1'b1);
      st(1'b0);
      wait_busy(1'b0, PROG + 20);
      st(1'b1);
      rd(8'h12, 16'ha55a);
      wr(8'hff, 16'hc3c3, 1'b1);
      wait_busy(1'b0, PROG + 20);
      rd(8'hff, 16'hc3c3);
      $display("test write read done");
   endtask

   task automatic t_disable();
      latch(CMD_PDIS, 1'b0);
      wr(8'h12, 16'h0f0f, 1'b0);
      rd(8'h12, 16'ha55a);
      $display("test disable done");
   endtask

   task automatic t_guard();
      guard = 1'b1;
      latch(CMD_PEN, 1'b1);
      wr(8'h12, 16'h1111, 1'b0);
      rd(8'h12, 16'ha55a);
      guard = 1'b0;
      step(2);
      $display("test guard done");
   endtask

   // an aborted word is left erased but not programmed
   task automatic t_abort();
      wr(8'h12, 16'h0000, 1'b1);
      guard = 1'b1;
      wait_busy(1'b0, 10);
      cmp_bit(busy, 1'b0);
      guard = 1'b0;
      step(2);
      rd(8'h12, 16'hffff);
      $display("test abort done");
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = CMD_READ;
      cmd_addr = 8'h00;
      cmd_data = 16'h0000;
      guard = 1'b0;
      err_total = 0;
      checks_done = 0;
      cyc_count = 0;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      t_locked();
      t_write_read();
      t_disable();
      t_guard();
      t_abort();
      conclude();
   end
endmodule
